// *** pkg/gate1_sel_pkg.sv ***
// Purpose: Shared constants and types for the gate 1 input selection stage
// Assumes: 8-bit register port, 32 selectable source signals
// Notes: Offsets index byte-wide registers on the plain register port
package gate1_sel_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SEL_W = 5;
  localparam int NUM_IN = 4;
  localparam int NUM_SRC = 32;

  // Register offsets
  localparam logic [7:0] OFS_SEL_FIRST = 8'h00;
  localparam logic [7:0] OFS_SEL_SECOND = 8'h01;
  localparam logic [7:0] OFS_SEL_THIRD = 8'h02;
  localparam logic [7:0] OFS_SEL_FOURTH = 8'h03;
  localparam logic [7:0] OFS_G1_ENABLE = 8'h04;

  // Reset values
  localparam logic [7:0] RST_G1_ENABLE = 8'h00;
  localparam logic [4:0] RST_SEL = 5'h00;
  localparam logic [7:0] RD_ZERO = 8'h00;

  // Field positions in the enable register
  localparam int BIT_IN4_TRUE = 7;
  localparam int BIT_IN4_NEG = 6;
  localparam int BIT_IN3_TRUE = 5;
  localparam int BIT_IN3_NEG = 4;
  localparam int BIT_IN2_TRUE = 3;
  localparam int BIT_IN2_NEG = 2;
  localparam int BIT_IN1_TRUE = 1;
  localparam int BIT_IN1_NEG = 0;

  typedef struct packed {
    logic g1_in4_true_en;
    logic g1_in4_neg_en;
    logic g1_in3_true_en;
    logic g1_in3_neg_en;
    logic g1_in2_true_en;
    logic g1_in2_neg_en;
    logic g1_in1_true_en;
    logic g1_in1_neg_en;
  } gate1_en_s;

endpackage : gate1_sel_pkg

// *** verilog/data_input_select.sv ***
// Purpose: Picks one of the synchronised sources as one cell data input
// Assumes: Sources already pass two flip-flops upstream
// Notes: Output registered, one cycle after the source
`timescale 1ns/10ps
module data_input_select (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [31:0] srcSync,
  input wire logic [4:0] sourceSelect,
  output logic dataOut
);

  logic dataOut_ff;
  logic nxt_dataOut;

  always_comb begin
    nxt_dataOut = srcSync[sourceSelect]; // [RQ5]
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      dataOut_ff <= 1'b0;
    end else begin
      dataOut_ff <= nxt_dataOut;
    end
  end

  assign dataOut = dataOut_ff;

  chk_mux_pick: assert property (@(posedge ref_clk) disable iff (!nrst) // [RQ5]
    1'b1 |=> dataOut == $past(srcSync[sourceSelect]))
    else $error("selected data input does not follow chosen source");

endmodule : data_input_select

// *** verilog/logic_cell_gate1_input_select.sv ***
// Purpose: Gate 1 input gating of a configurable logic cell
// Assumes: Sources come from outside the clock domain; plain register port
// Notes: Gate output lags a source change by four clock edges
//
// Function
// [RQ1] Bits 7 and 6 gate fourth data input true and inverted into gate 1.
// [RQ2] Bits 5 and 4 gate third data input true and inverted into gate 1.
// [RQ3] Bits 3 and 2 gate second data input true and inverted into gate 1.
// [RQ4] Bits 1 and 0 gate first data input true and inverted into gate 1.
// [RQ5] Each data input picks one source via its own five-bit select field.
// [RQ6] Gate 1 output is OR of enabled terms; low when nothing enabled.
`timescale 1ns/10ps
module logic_cell_gate1_input_select (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData,
  input wire logic [31:0] srcIn,
  output logic [3:0] cellData,
  output logic gate1Out
);

  // Source synchronisers
  logic [31:0] srcMeta_ff;
  logic [31:0] srcSync_ff;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      srcMeta_ff <= 32'h0000_0000;
      srcSync_ff <= 32'h0000_0000;
    end else begin
      srcMeta_ff <= srcIn;
      srcSync_ff <= srcMeta_ff;
    end
  end

  // Register file
  gate1_sel_pkg::gate1_en_s enReg_ff;
  gate1_sel_pkg::gate1_en_s nxt_enReg;
  logic [4:0] selReg_ff [4];
  logic [4:0] nxt_selReg [4];
  logic [7:0] rdData_ff;
  logic [7:0] nxt_rdData;

  always_comb begin
    nxt_enReg = enReg_ff;
    for (int i = 0; i < 4; i++) begin
      nxt_selReg[i] = selReg_ff[i];
    end
    if (wrStb) begin
      case (regAddr)
        gate1_sel_pkg::OFS_SEL_FIRST: begin
          nxt_selReg[0] = wrData[4:0]; // [RQ5]
        end
        gate1_sel_pkg::OFS_SEL_SECOND: begin
          nxt_selReg[1] = wrData[4:0]; // [RQ5]
        end
        gate1_sel_pkg::OFS_SEL_THIRD: begin
          nxt_selReg[2] = wrData[4:0]; // [RQ5]
        end
        gate1_sel_pkg::OFS_SEL_FOURTH: begin
          nxt_selReg[3] = wrData[4:0]; // [RQ5]
        end
        gate1_sel_pkg::OFS_G1_ENABLE: begin
          nxt_enReg = gate1_sel_pkg::gate1_en_s'(wrData);
        end
        default: begin
          nxt_enReg = enReg_ff;
        end
      endcase
    end
  end

  always_comb begin
    nxt_rdData = gate1_sel_pkg::RD_ZERO;
    if (rdStb) begin
      case (regAddr)
        gate1_sel_pkg::OFS_SEL_FIRST: begin
          nxt_rdData = {3'h0, selReg_ff[0]};
        end
        gate1_sel_pkg::OFS_SEL_SECOND: begin
          nxt_rdData = {3'h0, selReg_ff[1]};
        end
        gate1_sel_pkg::OFS_SEL_THIRD: begin
          nxt_rdData = {3'h0, selReg_ff[2]};
        end
        gate1_sel_pkg::OFS_SEL_FOURTH: begin
          nxt_rdData = {3'h0, selReg_ff[3]};
        end
        gate1_sel_pkg::OFS_G1_ENABLE: begin
          nxt_rdData = enReg_ff;
        end
        default: begin
          nxt_rdData = gate1_sel_pkg::RD_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      enReg_ff <= gate1_sel_pkg::RST_G1_ENABLE;
      rdData_ff <= gate1_sel_pkg::RD_ZERO;
      for (int i = 0; i < 4; i++) begin
        selReg_ff[i] <= gate1_sel_pkg::RST_SEL;
      end
    end else begin
      enReg_ff <= nxt_enReg;
      rdData_ff <= nxt_rdData;
      for (int i = 0; i < 4; i++) begin
        selReg_ff[i] <= nxt_selReg[i];
      end
    end
  end

  assign rdData = rdData_ff;

  // Data input selectors
  logic [3:0] dataSel;

  generate
    for (genvar g = 0; g < 4; g++) begin : gen_sel
      data_input_select u_sel (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .srcSync(srcSync_ff),
        .sourceSelect(selReg_ff[g]),
        .dataOut(dataSel[g])
      );
    end
  endgenerate

  assign cellData = dataSel;

  // Gate 1 term gating
  logic [7:0] enBits;
  logic [7:0] gateTerm;
  logic gate1Out_ff;
  logic nxt_gate1Out;

  assign enBits = enReg_ff;

  generate
    for (genvar k = 0; k < 4; k++) begin : gen_term
      // Odd bit gates the true form, even bit the inverted form
      assign gateTerm[2*k+1] = enBits[2*k+1] & dataSel[k]; // [RQ1] [RQ2] [RQ3] [RQ4]
      assign gateTerm[2*k] = enBits[2*k] & ~dataSel[k]; // [RQ1] [RQ2] [RQ3] [RQ4]
    end
  endgenerate

  always_comb begin
    nxt_gate1Out = |gateTerm; // [RQ6]
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      gate1Out_ff <= 1'b0;
    end else begin
      gate1Out_ff <= nxt_gate1Out;
    end
  end

  assign gate1Out = gate1Out_ff;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence enWrite;
    wrStb && regAddr == gate1_sel_pkg::OFS_G1_ENABLE;
  endsequence

  sequence enReadBack;
    rdStb && regAddr == gate1_sel_pkg::OFS_G1_ENABLE;
  endsequence

  chk_in4_true: assert property ( // [RQ1]
    enReg_ff.g1_in4_true_en && dataSel[3] |=> gate1Out)
    else $error("fourth input true term not gated in");

  chk_in4_neg: assert property ( // [RQ1]
    enReg_ff.g1_in4_neg_en && !dataSel[3] |=> gate1Out)
    else $error("fourth input inverted term not gated in");

  chk_in3_terms: assert property ( // [RQ2]
    (enReg_ff.g1_in3_true_en && dataSel[2]) || (enReg_ff.g1_in3_neg_en && !dataSel[2])
    |=> gate1Out)
    else $error("third input term not gated in");

  chk_in2_terms: assert property ( // [RQ3]
    (enReg_ff.g1_in2_true_en && dataSel[1]) || (enReg_ff.g1_in2_neg_en && !dataSel[1])
    |=> gate1Out)
    else $error("second input term not gated in");

  chk_in1_terms: assert property ( // [RQ4]
    (enReg_ff.g1_in1_true_en && dataSel[0]) || (enReg_ff.g1_in1_neg_en && !dataSel[0])
    |=> gate1Out)
    else $error("first input term not gated in");

  chk_excluded_low: assert property ( // [RQ1] [RQ2] [RQ3] [RQ4]
    (enReg_ff[7:6] == ({dataSel[3], !dataSel[3]} ^ 2'b11))
    && (enReg_ff[5:4] == ({dataSel[2], !dataSel[2]} ^ 2'b11))
    && (enReg_ff[3:2] == ({dataSel[1], !dataSel[1]} ^ 2'b11))
    && (enReg_ff[1:0] == ({dataSel[0], !dataSel[0]} ^ 2'b11)) |=> !gate1Out)
    else $error("excluded forms still drive gate 1");

  chk_none_low: assert property ( // [RQ6]
    enWrite ##0 (wrData == 8'h00) |=> ##1 !gate1Out)
    else $error("gate 1 not low with no term enabled");

  chk_enable_steer: assert property ( // [RQ6]
    enWrite |=> enReg_ff == $past(wrData) ##1 gate1Out == $past(|(enReg_ff
    & {dataSel[3], !dataSel[3], dataSel[2], !dataSel[2],
    dataSel[1], !dataSel[1], dataSel[0], !dataSel[0]})))
    else $error("enable write does not steer gate 1");

  chk_enable_read: assert property (
    enReadBack |=> rdData == $past(enReg_ff))
    else $error("enable register read back wrong");

  chk_sel_path: assert property ( // [RQ5]
    wrStb && regAddr == gate1_sel_pkg::OFS_SEL_FOURTH
    |=> selReg_ff[3] == $past(wrData[4:0]) ##1 dataSel[3] == $past(srcSync_ff[selReg_ff[3]]))
    else $error("fourth select field does not pick its source");

endmodule : logic_cell_gate1_input_select

// *** test/src_model.sv ***
// Purpose: Far-side source model feeding the cell's source lines
// Assumes: Sources change just after a rising edge, as real peripherals do
// Notes: Drives the bench pattern one edge late; zero during reset
`timescale 1ns/10ps
module src_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [31:0] pattern,
  output logic [31:0] srcIn
);
  logic [31:0] nxt_src;
  logic [31:0] src_ff;
  always_comb begin
    nxt_src = nrst ? pattern : 32'h0000_0000;
  end
  always_ff @(posedge ref_clk) begin
    src_ff <= nxt_src;
  end
  assign srcIn = src_ff;
endmodule : src_model

// *** test/tb_logic_cell_gate1_input_select.sv ***
// Purpose: Self-checking bench for the gate 1 input selection stage
// Assumes: Register port without wait states; four-edge source latency
// Notes: Every enable bit and several mixes are swept over all input values
`timescale 1ns/10ps
module tb_logic_cell_gate1_input_select;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic [7:0] rdData;
  logic [31:0] srcPattern = 32'h0000_0000;
  logic [31:0] srcIn;
  logic [3:0] cellData;
  logic gate1Out;
  int errTotal = 0;
  int checksDone = 0;
  logic [7:0] enTab [12] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80,
                             8'h00, 8'hAA, 8'h55, 8'hC3};

  always #5 ref_clk = ~ref_clk;

  src_model far (.ref_clk(ref_clk), .nrst(nrst), .pattern(srcPattern), .srcIn(srcIn));

  logic_cell_gate1_input_select dut (
    .ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData(rdData), .srcIn(srcIn), .cellData(cellData), .gate1Out(gate1Out)
  );

  task automatic tallyAndFinish();
    $display("errors %0d checks %0d", errTotal, checksDone);
    if (errTotal == 0 && checksDone > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tallyAndFinish

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errTotal++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge ref_clk);
    wrStb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    rdStb <= 1'b1;
    @(posedge ref_clk);
    rdStb <= 1'b0;
    #1 chk(rdData, e);
  endtask : rd

  // Source change, then enough edges for sync, select and gate stages
  task automatic drive(input logic [31:0] p);
    @(posedge ref_clk);
    srcPattern <= p;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask : drive

  function automatic logic gexp(input logic [7:0] en, input logic [3:0] d);
    gexp = 1'b0;
    for (int k = 0; k < 4; k++) begin
      gexp = gexp | (en[2*k+1] & d[k]) | (en[2*k] & ~d[k]);
    end
  endfunction : gexp

  initial begin
    repeat (20000) @(posedge ref_clk);
    errTotal++;
    $display("wrong value at %0t: run did not complete", $time);
    tallyAndFinish();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(i[7:0], 8'h00);
    end
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h00);
    rd(8'hFF, 8'h00);
    wr(gate1_sel_pkg::OFS_SEL_FIRST, 8'hFF);
    rd(gate1_sel_pkg::OFS_SEL_FIRST, 8'h1F);
    drive(32'h8000_0000);
    chk({4'h0, cellData}, 8'h01);
    drive(32'h7FFF_FFFF);
    chk({4'h0, cellData}, 8'h0E);
    for (int i = 0; i < 4; i++) begin
      wr(gate1_sel_pkg::OFS_SEL_FIRST + i[7:0], i[7:0]);
    end
    rd(gate1_sel_pkg::OFS_SEL_FOURTH, 8'h03);
    foreach (enTab[j]) begin
      wr(gate1_sel_pkg::OFS_G1_ENABLE, enTab[j]);
      rd(gate1_sel_pkg::OFS_G1_ENABLE, enTab[j]);
      for (int v = 0; v < 16; v++) begin
        drive({28'h000_0000, v[3:0]});
        chk({4'h0, cellData}, {4'h0, v[3:0]});
        chk({7'h00, gate1Out}, {7'h00, gexp(enTab[j], v[3:0])});
      end
    end
    tallyAndFinish();
  end
endmodule : tb_logic_cell_gate1_input_select
